// ### sysctl_pkg.sv
// Shared constants and carrier types for the system status/control ports
// ==========================================================
// Functional notes
// - Control bit 7 high: port 060h shows status one, keyboard blocked.
// - Each received key code is latched and raises the level 1 interrupt.
// - Keyboard data held low while its interrupt is pending.
// - Keyboard clock edges accepted only while control bit 6 is set.
// - Control bit 5 keeps channel check from raising NMI, cancels pending.
// - Pulsing bit 5 clears latched channel check once source withdrew.
// - Control bit 4 disables parity checking; status two bit 7 reads 0.
// - Control bit 2 selects memory-size bits 3..0, else bit 4 at bit 0.
// - Control bit 1 drives the speaker together with the tone output.
// - Control bit 0 drives the gate of tone counter 2.
// - Port 060h read-only; status one fixed bits 7=0, 3,2,0=1.
// - Display mode bits: 00 ext, 01 40x25, 10 80x25, 11 mono.
// - Port 062h read-only; bit7 onboard parity, 6 ext, 5 tone, 4 zero.
// - Status bit 6 live check input when bit 5 high, else latched.
// - Memory-size code 01110..10010 means 512K..640K fitted.
// - Write to 064h loads bits 6,5,4,1 of status one.
// - Write to 065h loads memory-size bits 4..0.
// - Any write to 066h fires a 512 us system and bus reset pulse.
// - Software reset leaves system memory contents untouched.
// - Control port lives at 061h.
// - Port directions are fixed; reset never changes them.
package sysctl_pkg;
	localparam int ADDR_W = 10;
	localparam logic [9:0] ADDR_STATUS_ONE = 10'h060;
	localparam logic [9:0] ADDR_CONTROL    = 10'h061;
	localparam logic [9:0] ADDR_STATUS_TWO = 10'h062;
	localparam logic [9:0] ADDR_PRESET_ONE = 10'h064;
	localparam logic [9:0] ADDR_PRESET_TWO = 10'h065;
	localparam logic [9:0] ADDR_SYS_RESET  = 10'h066;
	// Control bit positions
	localparam int CB_STATUS_SEL = 7;
	localparam int CB_KBD_CLK_EN = 6;
	localparam int CB_NMI_BLOCK  = 5;
	localparam int CB_PARITY_OFF = 4;
	localparam int CB_MEM_LOW    = 2;
	localparam int CB_SPEAKER    = 1;
	localparam int CB_TONE_GATE  = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] PRESET_RESET  = 8'h00;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;
	// Status one: fixed ones at 3,2,0; preset bits 6,5,4,1
	localparam logic [7:0] ST1_FIXED_ONES = 8'h0D;
	localparam logic [7:0] ST1_PRESET_MSK = 8'h72;
	localparam logic [4:0] MEM_512K = 5'h0E;
	localparam logic [4:0] MEM_640K = 5'h12;
	localparam int KBD_FRAME_BITS = 9;
	localparam logic [3:0] KBD_LAST_BIT = 4'h8;
	localparam int CLK_MHZ = 40;
	localparam int RESET_PULSE_US = 512;
	localparam int RESET_PULSE_CYC = RESET_PULSE_US * CLK_MHZ;
	typedef enum logic [1:0] {
		DISP_EXT_ADAPTER,
		DISP_COLOUR_40,
		DISP_COLOUR_80,
		DISP_MONO_80
	} disp_mode_e;
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} io_req_s;
endpackage

// ### kbd_receiver.sv
// Keyboard serial code receiver: start bit then eight data bits, LSB first
`timescale 1ns/1ps
module kbd_receiver
	import sysctl_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Link
	input  wire logic       kbd_clk,
	input  wire logic       kbd_data,
	input  wire logic       enable,
	// Result
	output logic [7:0]      code,
	output logic            code_valid
);
	import sysctl_pkg::*;

	logic       clk_prev;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	wire        fall     = clk_prev & ~kbd_clk;
	wire        take     = fall & enable;
	wire        last_bit = (bit_cnt == KBD_LAST_BIT);

	always_ff @(posedge mclk or posedge rst)
		if (rst)
			clk_prev <= 1'b1;
		else
			clk_prev <= kbd_clk;

	// Edges outside the enable window are dropped, not counted
	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			bit_cnt <= '0;
			shift <= '0;
			code <= '0;
			code_valid <= 1'b0;
		end
		else
		begin
			code_valid <= take & last_bit;
			if (take)
			begin
				bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
				if (bit_cnt != 4'h0)
					shift <= {kbd_data, shift[7:1]};
				if (last_bit)
					code <= {kbd_data, shift[7:1]};
			end
		end
endmodule

// ### reset_pulser.sv
// Fixed-length system reset pulse generator
`timescale 1ns/1ps
module reset_pulser
	import sysctl_pkg::*;
#(
	parameter int PULSE_CYC = RESET_PULSE_CYC
)
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Trigger and pulse
	input  wire logic fire,
	output logic      pulse
);
	import sysctl_pkg::*;

	logic [15:0] remain;

	// A write during an active pulse restarts the full length
	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			remain <= '0;
			pulse <= 1'b0;
		end
		else if (fire)
		begin
			remain <= 16'(PULSE_CYC - 1);
			pulse <= 1'b1;
		end
		else if (remain != '0)
			remain <= remain - 16'h1;
		else
			pulse <= 1'b0;
endmodule

// ### system_status_control_ports.sv
// System status/control ports: control, two status reads, presets, reset
`timescale 1ns/1ps
module system_status_control_ports
	import sysctl_pkg::*;
#(
	parameter int RESET_CYC = RESET_PULSE_CYC
)
(
	// Clock and reset
	input  wire logic                mclk,
	input  wire logic                rst,
	// Processor byte I/O
	input  wire sysctl_pkg::io_req_s io_req,
	output logic [7:0]               io_rdata,
	output logic                     io_rvalid,
	// Keyboard link (open drain data)
	input  wire logic                kbd_clk,
	input  wire logic                kbd_data_in,
	output logic                     kbd_data_out,
	output logic                     kbd_data_oe,
	output logic                     kbd_irq,
	// Parity and NMI
	input  wire logic                ram_parity_fault,
	input  wire logic                expansion_channel_check,
	input  wire logic                nmi_unmask,
	output logic                     nmi,
	// Tone timer and speaker
	input  wire logic                tone_out,
	output logic                     tone_gate,
	output logic                     speaker_out,
	// Software reset
	output logic                     sys_reset_out,
	output logic                     bus_reset_out
);
	import sysctl_pkg::*;

	// ==========================================================
	// State
	logic [7:0] system_control_out;
	logic [7:0] status_one_preset;
	logic [7:0] status_two_preset;
	logic [7:0] key_code;
	logic       kbd_pending;
	logic       onboard_parity_err;
	logic       chk_latched;
	logic [7:0] rx_code;
	logic       rx_valid;
	logic       reset_pulse;

	// ==========================================================
	// Address decode
	wire hit_st1  = io_req.addr == ADDR_STATUS_ONE;
	wire hit_ctl  = io_req.addr == ADDR_CONTROL;
	wire hit_st2  = io_req.addr == ADDR_STATUS_TWO;
	wire hit_pre1 = io_req.addr == ADDR_PRESET_ONE;
	wire hit_pre2 = io_req.addr == ADDR_PRESET_TWO;
	wire hit_rst  = io_req.addr == ADDR_SYS_RESET;
	// Writes to the status ports are dropped: directions never change
	wire wr_ctl  = io_req.wr & hit_ctl;
	wire wr_pre1 = io_req.wr & hit_pre1;
	wire wr_pre2 = io_req.wr & hit_pre2;
	wire wr_rst  = io_req.wr & hit_rst;

	// ==========================================================
	// Control bit views
	wire status_select_kbd_disable = system_control_out[CB_STATUS_SEL];
	wire kbd_clk_enable            = system_control_out[CB_KBD_CLK_EN];
	wire ext_parity_nmi_block      = system_control_out[CB_NMI_BLOCK];
	wire ram_parity_check_off      = system_control_out[CB_PARITY_OFF];
	wire mem_size_low_select       = system_control_out[CB_MEM_LOW];
	wire speaker_drive_bit         = system_control_out[CB_SPEAKER];
	wire tone_gate_bit             = system_control_out[CB_TONE_GATE];

	// ==========================================================
	// Read data selection
	wire [4:0] mem_size = status_two_preset[4:0];
	wire [1:0] default_disp = status_one_preset[5:4];
	wire [7:0] status_one_val =
		(status_one_preset & ST1_PRESET_MSK) | ST1_FIXED_ONES;
	wire [7:0] port_a_val =
		status_select_kbd_disable ? status_one_val : key_code;
	wire       ext_err_view = ext_parity_nmi_block ?
		expansion_channel_check : chk_latched;
	wire [3:0] mem_view = mem_size_low_select ?
		mem_size[3:0] : {3'b000, mem_size[4]};
	wire [7:0] port_c_val = {onboard_parity_err & ~ram_parity_check_off,
		ext_err_view, tone_out, 1'b0, mem_view};
	wire [7:0] read_mux = hit_st1 ? port_a_val :
		hit_ctl ? system_control_out :
		hit_st2 ? port_c_val : UNMAPPED_DATA;

	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			io_rdata <= UNMAPPED_DATA;
			io_rvalid <= 1'b0;
		end
		else
		begin
			io_rvalid <= io_req.rd;
			if (io_req.rd)
				io_rdata <= read_mux;
		end

	// ==========================================================
	// Control and preset registers
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			system_control_out <= CONTROL_RESET;
		else if (wr_ctl)
			system_control_out <= io_req.wdata;

	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			status_one_preset <= PRESET_RESET;
			status_two_preset <= PRESET_RESET;
		end
		else
		begin
			if (wr_pre1)
				status_one_preset <= io_req.wdata & ST1_PRESET_MSK;
			if (wr_pre2)
				status_two_preset <= {3'b000, io_req.wdata[4:0]};
		end

	// ==========================================================
	// Keyboard path
	wire rx_enable = kbd_clk_enable & ~status_select_kbd_disable &
		~kbd_pending;

	kbd_receiver u_kbd (
		.mclk       (mclk),
		.rst        (rst),
		.kbd_clk    (kbd_clk),
		.kbd_data   (kbd_data_in),
		.enable     (rx_enable),
		.code       (rx_code),
		.code_valid (rx_valid)
	);

	// Writing bit 7 high acknowledges the code; a new code in that cycle wins
	wire kbd_clear = wr_ctl & io_req.wdata[CB_STATUS_SEL];

	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			key_code <= '0;
			kbd_pending <= 1'b0;
		end
		else
		begin
			if (rx_valid)
				key_code <= rx_code;
			if (rx_valid)
				kbd_pending <= 1'b1;
			else if (kbd_clear)
				kbd_pending <= 1'b0;
		end

	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			kbd_irq <= 1'b0;
			kbd_data_oe <= 1'b0;
			kbd_data_out <= 1'b0;
		end
		else
		begin
			kbd_irq <= kbd_pending & ~status_select_kbd_disable;
			kbd_data_oe <= kbd_pending;
			kbd_data_out <= 1'b0;
		end

	// ==========================================================
	// Parity and NMI
	// The channel check latch clears only once the source has let go,
	// so a stuck source cannot be silently lost by pulsing bit 5.
	wire chk_set = expansion_channel_check & ~ext_parity_nmi_block;
	wire chk_clr = ext_parity_nmi_block & ~expansion_channel_check;

	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			chk_latched <= 1'b0;
			onboard_parity_err <= 1'b0;
		end
		else
		begin
			if (chk_set)
				chk_latched <= 1'b1;
			else if (chk_clr)
				chk_latched <= 1'b0;
			if (ram_parity_check_off)
				onboard_parity_err <= 1'b0;
			else if (ram_parity_fault)
				onboard_parity_err <= 1'b1;
		end

	always_ff @(posedge mclk or posedge rst)
		if (rst)
			nmi <= 1'b0;
		else
			nmi <= nmi_unmask & (onboard_parity_err |
				(chk_latched & ~ext_parity_nmi_block));

	// ==========================================================
	// Speaker and tone gate
	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			speaker_out <= 1'b0;
			tone_gate <= 1'b0;
		end
		else
		begin
			speaker_out <= speaker_drive_bit & tone_out;
			tone_gate <= tone_gate_bit;
		end

	// ==========================================================
	// Software reset: pulses outward only; no memory is touched here
	reset_pulser #(
		.PULSE_CYC (RESET_CYC)
	) u_rst (
		.mclk  (mclk),
		.rst   (rst),
		.fire  (wr_rst),
		.pulse (reset_pulse)
	);

	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			sys_reset_out <= 1'b0;
			bus_reset_out <= 1'b0;
		end
		else
		begin
			sys_reset_out <= reset_pulse;
			bus_reset_out <= reset_pulse;
		end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	status_one_read_a: assert property (
		io_req.rd && hit_st1 && status_select_kbd_disable |=>
		io_rdata[7] == 1'b0 && io_rdata[3:2] == 2'b11 && io_rdata[0])
		else $error("status one fixed bits wrong");
	kbd_ack_low_a: assert property (
		kbd_pending |=> kbd_data_oe && !kbd_data_out)
		else $error("keyboard data not held low");
	kbd_clk_gate_a: assert property (
		rx_valid |-> $past(kbd_clk_enable) && !$past(kbd_pending))
		else $error("code taken with clock gated");
	nmi_block_a: assert property (
		ext_parity_nmi_block && !onboard_parity_err |=> !nmi)
		else $error("nmi raised while blocked");
	chk_clear_a: assert property (
		ext_parity_nmi_block && !expansion_channel_check |=> !chk_latched)
		else $error("channel check not cleared");
	parity_mask_a: assert property (
		io_req.rd && hit_st2 && ram_parity_check_off |=> !io_rdata[7])
		else $error("parity bit seen while disabled");
	speaker_and_a: assert property (
		speaker_out == ($past(speaker_drive_bit) & $past(tone_out)))
		else $error("speaker drive mismatch");
	tone_gate_a: assert property (
		$past(wr_ctl) |=> tone_gate == $past(io_req.wdata[CB_TONE_GATE], 2))
		else $error("tone gate mismatch");
	sw_reset_a: assert property (
		wr_rst |-> ##2 sys_reset_out && bus_reset_out)
		else $error("reset pulse not started");

	disp_mode_a: assert property (
		io_req.rd && hit_st1 && status_select_kbd_disable |=>
		io_rdata[5:4] == $past(default_disp))
		else $error("display mode bits wrong");
	key_read_a: assert property (
		io_req.rd && hit_st1 && !status_select_kbd_disable |=>
		io_rdata == $past(key_code))
		else $error("key code read wrong");
	kbd_irq_a: assert property (
		kbd_pending && !status_select_kbd_disable |=> kbd_irq)
		else $error("keyboard interrupt not raised");
	kbd_mask_a: assert property (
		status_select_kbd_disable |=> !kbd_irq)
		else $error("keyboard interrupt not masked");
	mem_low_a: assert property (
		io_req.rd && hit_st2 && mem_size_low_select |=>
		io_rdata[3:0] == $past(mem_size[3:0]))
		else $error("memory size low bits wrong");
	mem_high_a: assert property (
		io_req.rd && hit_st2 && !mem_size_low_select |=>
		io_rdata[0] == $past(mem_size[4]))
		else $error("memory size top bit wrong");
	tone_bit_a: assert property (
		io_req.rd && hit_st2 |=>
		io_rdata[5] == $past(tone_out) && !io_rdata[4])
		else $error("tone status bit wrong");
	ext_live_a: assert property (
		io_req.rd && hit_st2 && ext_parity_nmi_block |=>
		io_rdata[6] == $past(expansion_channel_check))
		else $error("live channel check not shown");
	ext_latch_a: assert property (
		io_req.rd && hit_st2 && !ext_parity_nmi_block |=>
		io_rdata[6] == $past(chk_latched))
		else $error("latched channel check not shown");
	preset_one_a: assert property (
		wr_pre1 |=>
		status_one_preset == ($past(io_req.wdata) & ST1_PRESET_MSK))
		else $error("status one preset wrong");
	preset_two_a: assert property (
		wr_pre2 |=> mem_size == $past(io_req.wdata[4:0]))
		else $error("memory size preset wrong");
	ctrl_write_a: assert property (
		wr_ctl |=> system_control_out == $past(io_req.wdata))
		else $error("control write lost");
	read_valid_a: assert property (
		io_rvalid == $past(io_req.rd))
		else $error("read valid timing wrong");
	nmi_parity_a: assert property (
		onboard_parity_err && nmi_unmask |=> nmi)
		else $error("parity error did not raise nmi");
	reset_pair_a: assert property (
		sys_reset_out == bus_reset_out)
		else $error("system and bus reset differ");

	// ==========================================================
	// Pulse length watch
	// Counts edges since the last reset-port write and stops past the end,
	// so a long idle run never wraps back into the pulse window
	localparam logic [15:0] PULSE_LAST = 16'(RESET_CYC);
	logic [15:0] since_fire;
	logic        fired;

	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			since_fire <= '0;
			fired <= 1'b0;
		end
		else if (wr_rst)
		begin
			since_fire <= '0;
			fired <= 1'b1;
		end
		else if (since_fire <= PULSE_LAST)
			since_fire <= since_fire + 16'h1;

	// The edge right after a restart still shows the old pulse; skip it
	reset_len_a: assert property (
		fired && !$past(wr_rst) |->
		sys_reset_out == (since_fire != '0 && since_fire <= PULSE_LAST))
		else $error("reset pulse length wrong");

	kbd_code_c: cover property (rx_valid ##[1:20] kbd_clear);
	nmi_c: cover property (chk_set ##[1:20] chk_clr);
	reset_c: cover property ($rose(sys_reset_out));
	disp_mono_c: cover property (io_req.rd && hit_st1 &&
		default_disp == DISP_MONO_80);
	parity_nmi_c: cover property (onboard_parity_err ##1 nmi);
endmodule

// ### kbd_partner.sv
// Keyboard model: start bit then eight data bits, LSB first
`timescale 1ns/1ps
module kbd_partner
(
	// Clock
	input  wire logic mclk,
	// Link
	input  wire logic data_line,
	output logic      kclk,
	output logic      kdata
);
	// ==========
	// Frame sender
	initial
	begin
		kclk = 1'b1;
		kdata = 1'b1;
	end

	// Clock stays high between frames; data released to the pull-up
	task automatic send(input logic [7:0] code);
		logic [8:0] bits;
		bits = {code, 1'b0};
		while (data_line !== 1'b1)
			@(posedge mclk);
		for (int i = 0; i < 9; i++)
		begin
			@(posedge mclk);
			#1 kdata = bits[i];
			repeat (3) @(posedge mclk);
			#1 kclk = 1'b0;
			repeat (3) @(posedge mclk);
			#1 kclk = 1'b1;
		end
		@(posedge mclk);
		#1 kdata = 1'b1;
	endtask
endmodule

// ### system_status_control_ports_test.sv
// Self-checking bench for the system status/control ports
`timescale 1ns/1ps
module system_status_control_ports_test;
	import sysctl_pkg::*;
	localparam int RCYC = 16;
	logic       mclk, rst, io_rvalid, kbd_clk, kdata, kbd_line;
	logic       kbd_data_out, kbd_data_oe, kbd_irq, nmi, nmi_unmask;
	logic       ram_parity_fault, expansion_channel_check;
	logic       tone_out, tone_gate, speaker_out;
	logic       sys_reset_out, bus_reset_out;
	io_req_s    io_req;
	logic [7:0] io_rdata, r;
	logic [7:0] expq[$];
	logic [4:0] mem;
	logic [4:0] sizes[5] = '{5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12};
	int         failures, num_checks, cyc, n;

	// Open-drain data: device pull-down wins over the keyboard
	assign kbd_line = (kbd_data_oe ? kbd_data_out : 1'b1) & kdata;

	system_status_control_ports #(.RESET_CYC(RCYC)) dut
	(
		.mclk                    (mclk),
		.rst                     (rst),
		.io_req                  (io_req),
		.io_rdata                (io_rdata),
		.io_rvalid               (io_rvalid),
		.kbd_clk                 (kbd_clk),
		.kbd_data_in             (kbd_line),
		.kbd_data_out            (kbd_data_out),
		.kbd_data_oe             (kbd_data_oe),
		.kbd_irq                 (kbd_irq),
		.ram_parity_fault        (ram_parity_fault),
		.expansion_channel_check (expansion_channel_check),
		.nmi_unmask              (nmi_unmask),
		.nmi                     (nmi),
		.tone_out                (tone_out),
		.tone_gate               (tone_gate),
		.speaker_out             (speaker_out),
		.sys_reset_out           (sys_reset_out),
		.bus_reset_out           (bus_reset_out)
	);

	kbd_partner kb
	(
		.mclk      (mclk),
		.data_line (kbd_line),
		.kclk      (kbd_clk),
		.kdata     (kdata)
	);

	// ==========
	// Checking and closing
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Read answers are compared against the oldest note
	always @(negedge mclk)
		if (io_rvalid === 1'b1)
			check(io_rdata, expq.pop_front());

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			give_verdict();
		end
	end

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// ==========
	// Bus cycles
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 io_req = '{1'b0, 1'b1, a, d};
		@(posedge mclk);
		#1 io_req.wr = 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge mclk);
		expq.push_back(e);
		#1 io_req = '{1'b1, 1'b0, a, 8'h00};
		@(posedge mclk);
		#1 io_req.rd = 1'b0;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	// ==========
	// Scenarios
	initial
	begin
		rst = 1'b1;
		io_req = '0;
		ram_parity_fault = 1'b0;
		expansion_channel_check = 1'b0;
		nmi_unmask = 1'b0;
		tone_out = 1'b1;
		void'($urandom(71));
		tick(3);
		rst = 1'b0;
		rd(ADDR_CONTROL, 8'h00);
		check(8'({tone_gate, speaker_out, sys_reset_out}), 8'h00);
		$display("test reset done");

		wr(ADDR_CONTROL, 8'h80);
		rd(ADDR_CONTROL, 8'h80);
		for (int m = 0; m < 4; m++)
		begin
			r = 8'($urandom);
			r[5:4] = 2'(m);
			wr(ADDR_PRESET_ONE, r);
			rd(ADDR_STATUS_ONE, (r & 8'h72) | 8'h0D);
		end
		wr(ADDR_STATUS_ONE, ~r);
		rd(ADDR_STATUS_ONE, (r & 8'h72) | 8'h0D);
		rd(10'h067, 8'h00);
		$display("test status one done");

		foreach (sizes[k])
		begin
			mem = sizes[k];
			wr(ADDR_PRESET_TWO, {3'($urandom), mem});
			wr(ADDR_STATUS_TWO, 8'hFF);
			wr(ADDR_CONTROL, 8'h84);
			rd(ADDR_STATUS_TWO, {4'h2, mem[3:0]});
			wr(ADDR_CONTROL, 8'h80);
			rd(ADDR_STATUS_TWO, {7'h10, mem[4]});
		end
		$display("test status two done");

		wr(ADDR_CONTROL, 8'h00);
		kb.send(8'h5A);
		tick(20);
		check(8'(kbd_irq), 8'h00);
		wr(ADDR_CONTROL, 8'h40);
		repeat (2)
		begin
			r = 8'($urandom);
			kb.send(r);
			for (int i = 0; i < 50 && kbd_irq !== 1'b1; i++)
				tick(1);
			check(8'({kbd_irq, kbd_data_oe, kbd_line}), 8'h06);
			rd(ADDR_STATUS_ONE, r);
			wr(ADDR_CONTROL, 8'hC0);
			tick(3);
			check(8'({kbd_irq, kbd_data_oe}), 8'h00);
			wr(ADDR_CONTROL, 8'h40);
		end
		$display("test keyboard done");

		wr(ADDR_CONTROL, 8'h00);
		nmi_unmask = 1'b1;
		expansion_channel_check = 1'b1;
		tick(3);
		expansion_channel_check = 1'b0;
		tick(3);
		check(8'(nmi), 8'h01);
		rd(ADDR_STATUS_TWO, {7'h30, mem[4]});
		expansion_channel_check = 1'b1;
		wr(ADDR_CONTROL, 8'h20);
		tick(2);
		check(8'(nmi), 8'h00);
		rd(ADDR_STATUS_TWO, {7'h30, mem[4]});
		expansion_channel_check = 1'b0;
		rd(ADDR_STATUS_TWO, {7'h10, mem[4]});
		wr(ADDR_CONTROL, 8'h00);
		tick(2);
		check(8'(nmi), 8'h00);
		ram_parity_fault = 1'b1;
		tick(1);
		ram_parity_fault = 1'b0;
		tick(2);
		check(8'(nmi), 8'h01);
		rd(ADDR_STATUS_TWO, {7'h50, mem[4]});
		wr(ADDR_CONTROL, 8'h10);
		rd(ADDR_STATUS_TWO, {7'h10, mem[4]});
		$display("test parity done");

		wr(ADDR_CONTROL, 8'h03);
		tick(2);
		check(8'({tone_gate, speaker_out}), 8'h03);
		tone_out = 1'b0;
		tick(2);
		check(8'({tone_gate, speaker_out}), 8'h02);
		wr(ADDR_CONTROL, 8'h00);
		tick(2);
		check(8'(tone_gate), 8'h00);
		$display("test speaker done");

		wr(ADDR_SYS_RESET, 8'($urandom));
		n = 0;
		repeat (RCYC + 8)
		begin
			tick(1);
			if (sys_reset_out === 1'b1 && bus_reset_out === 1'b1)
				n++;
		end
		check(8'(n), 8'(RCYC));
		$display("test system reset done");
		tick(4);
		give_verdict();
	end
endmodule
